// [cocl_line_ctrl.sv]
// Output line source routing, user levels and line level read-back
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps

// Functional notes
// - Output 1 defaults to exposure in progress
// - Output 2 defaults to frame trigger waiting
// - User level only acts on user-sourced lines
// - Single user level drives picked line
// - Multi value low two bits set both
// - Multi value bit 0 low, 1 high
// - User value applied ahead of inverter
// - One read captures all line levels
// - Status word is 32 bits, fixed positions
// - Status bit 1 high, 0 low
// - Picked line status reports its level
// - Picked line reports polarity kind
// - Each output has a selectable source
// - Off source disables the output
// - Per-line inversion enable
module cocl_line_ctrl
	import cocl_pkg::*;
(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	// Register port
	input  wire cocl_pkg::cocl_bus_s  bus,
	output logic [31:0]               rdata,
	// Internal camera events, same clock
	input  wire cocl_pkg::cocl_evt_s  evt,
	// Input pin
	input  wire logic                 in_line_pin,
	// Output pins
	output logic [1:0]                out_line,
	output logic [1:0]                out_line_oe
);
	import cocl_pkg::*;

	// Register map, all byte addresses:
	//   0x00 line pick, 0x04 source, 0x08 inverter, 0x0C user line pick,
	//   0x10 user level, 0x14 multi value, 0x18 picked line status,
	//   0x1C snapshot, 0x20 polarity kind
	// Per-line registers act on the line named by the line pick; a pick that
	// names the input line leaves source and inverter alone and reads zero.
	// The slave never stalls: writes land on the strobe edge, reads answer
	// one cycle later and drop back to zero after that.

	// All module state
	typedef struct packed {
		logic [1:0]  io_line_pick;          // Selector for per-line access
		cocl_src_e   src1;                  // Source of output line 2
		cocl_src_e   src0;                  // Source of output line 1
		logic [1:0]  inv;                   // Inverter enables
		logic        user_driven_line_pick; // 0 = output 1, 1 = output 2
		logic [31:0] user_multi;            // Multi-line user value
		logic [1:0]  out_q;                 // Registered pin levels
		logic [1:0]  oe_q;                  // Registered pin enables
		logic [1:0]  in_sync;               // Input synchroniser
		logic [31:0] rdata;                 // Read data, one cycle later
	} cocl_state_s;

	cocl_state_s st;      // Current state
	cocl_state_s next_st; // Next state

	// Source mux for one line
	function automatic logic pick_source(input cocl_src_e s, input cocl_evt_s e,
		input logic user);
		case (s)
			SRC_EXPOSURE: pick_source = e.exposure_in_progress;
			SRC_ACQ_WAIT: pick_source = e.acquisition_trigger_waiting;
			SRC_FRM_WAIT: pick_source = e.frame_trigger_waiting;
			SRC_LIN_WAIT: pick_source = e.line_trigger_waiting;
			SRC_ENCODER:  pick_source = e.encoder_module_output;
			SRC_RATECONV: pick_source = e.rate_converter_output;
			SRC_USER:     pick_source = user;
			default:      pick_source = 1'b0;
		endcase
	endfunction

	// Legalise a written source code; unknown codes fall back to off
	function automatic cocl_src_e to_source(input logic [31:0] w);
		if (w <= 32'h0000_0007)
			to_source = cocl_src_e'(w[3:0]);
		else
			to_source = SRC_OFF;
	endfunction

	// Pre-inverter and pin levels per output line
	logic [1:0] raw_lvl;  // Selected source, before inverter
	logic [1:0] pin_lvl;  // After inverter
	logic [1:0] pin_oe;   // Drive enable
	logic [31:0] snap;    // All-lines level word

	// An off line parks its pin low, so a disabled output with the inverter
	// on never reads back as high
	// Route each line through its source mux and inverter
	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++)
		begin : g_line
			cocl_src_e sel;
			assign sel = (g == 0) ? st.src0 : st.src1;
			// Non-user sources ignore the user value entirely
			assign raw_lvl[g] = pick_source(sel, evt, st.user_multi[g]);
			// User value sits ahead of the inverter; off lines stay low
			assign pin_lvl[g] = pin_oe[g] & (raw_lvl[g] ^ st.inv[g]);
			assign pin_oe[g]  = (sel != SRC_OFF);
		end
	endgenerate

	// Snapshot word: input line in bit 0, outputs from bit 2
	// Only one input line is fitted, so bit 1 stays zero as a spare
	// Limitation: output bits are the registered drive, not a sense of the pin
	always_comb
	begin
		snap = 32'h0000_0000;
		snap[SNAP_IN1_BIT] = st.in_sync[1];
		// Driven pin levels, read back after the inverter
		snap[SNAP_OUT1_BIT +: NUM_OUT] = st.out_q;
	end

	// Next-state logic: register writes, reads and pin updates
	always_comb
	begin
		next_st = st;
		next_st.in_sync = {st.in_sync[0], in_line_pin};
		next_st.out_q   = pin_lvl;
		next_st.oe_q    = pin_oe;
		next_st.rdata   = UNMAPPED_READ;
		// Writes
		if (bus.wr)
		begin
			case (bus.addr)
				REG_LINE_PICK:
					next_st.io_line_pick = bus.wdata[1:0];
				REG_SOURCE:
					// Only output lines carry a source
					if (st.io_line_pick == PICK_OUT1)
						next_st.src0 = to_source(bus.wdata);
					else if (st.io_line_pick == PICK_OUT2)
						next_st.src1 = to_source(bus.wdata);
				REG_INVERT:
					if (st.io_line_pick == PICK_OUT1)
						next_st.inv[0] = bus.wdata[0];
					else if (st.io_line_pick == PICK_OUT2)
						next_st.inv[1] = bus.wdata[0];
				REG_USER_PICK:
					next_st.user_driven_line_pick = bus.wdata[0];
				REG_USER_LEVEL:
					// Single-line write touches only the picked bit
					next_st.user_multi[st.user_driven_line_pick] = bus.wdata[0];
				REG_USER_MULTI:
					// Both lines set in one write; full word held for read-back
					next_st.user_multi = bus.wdata;
				default:
					next_st.user_multi = st.user_multi; // Unmapped write ignored
			endcase
		end
		// Reads, answered in the following cycle
		if (bus.rd)
		begin
			case (bus.addr)
				REG_LINE_PICK:   next_st.rdata = {30'h0, st.io_line_pick};
				REG_SOURCE:
					if (st.io_line_pick == PICK_OUT1)
						next_st.rdata = {28'h0, st.src0};
					else if (st.io_line_pick == PICK_OUT2)
						next_st.rdata = {28'h0, st.src1};
					else
						next_st.rdata = UNMAPPED_READ;
				REG_INVERT:
					if (st.io_line_pick == PICK_OUT1)
						next_st.rdata = {31'h0, st.inv[0]};
					else if (st.io_line_pick == PICK_OUT2)
						next_st.rdata = {31'h0, st.inv[1]};
					else
						next_st.rdata = UNMAPPED_READ;
				REG_USER_PICK:   next_st.rdata = {31'h0, st.user_driven_line_pick};
				REG_USER_LEVEL:
					next_st.rdata = {31'h0, st.user_multi[st.user_driven_line_pick]};
				REG_USER_MULTI:  next_st.rdata = st.user_multi;
				// Whole-word capture at one instant
				REG_SNAPSHOT:    next_st.rdata = snap;
				REG_LINE_STATUS:
					case (st.io_line_pick)
						PICK_IN1:  next_st.rdata = {31'h0, snap[SNAP_IN1_BIT]};
						PICK_OUT1: next_st.rdata = {31'h0, snap[SNAP_OUT1_BIT]};
						PICK_OUT2: next_st.rdata = {31'h0, snap[SNAP_OUT1_BIT + 1]};
						default:   next_st.rdata = UNMAPPED_READ;
					endcase
				REG_POLARITY:
					// Outputs with inverter on are negative logic; input is positive
					case (st.io_line_pick)
						PICK_OUT1: next_st.rdata = st.inv[0] ? POL_NEGATIVE : POL_POSITIVE;
						PICK_OUT2: next_st.rdata = st.inv[1] ? POL_NEGATIVE : POL_POSITIVE;
						default:   next_st.rdata = POL_POSITIVE;
					endcase
				default:         next_st.rdata = UNMAPPED_READ;
			endcase
		end
	end

	// State register
	// Synchronous reset; the first edge after release already routes the
	// default sources to the pins
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st.io_line_pick          <= PICK_OUT1;
			st.src0                  <= SRC_EXPOSURE;
			st.src1                  <= SRC_FRM_WAIT;
			st.inv                   <= 2'h0;
			st.user_driven_line_pick <= 1'b0;
			st.user_multi            <= USER_MULTI_RESET;
			st.out_q                 <= 2'h0;
			st.oe_q                  <= 2'h0;
			st.in_sync               <= 2'h0;
			st.rdata                 <= UNMAPPED_READ;
		end
		else
			st <= next_st;
	end

	// Outputs from flip-flops
	assign rdata       = st.rdata;
	assign out_line    = st.out_q;
	assign out_line_oe = st.oe_q;

	// Defaults after reset
	a_reset_src_one: assert property (@(posedge ref_clk)
		($past(rst) && !rst) |-> st.src0 == SRC_EXPOSURE)
		else $error("output 1 source not exposure after reset");
	a_reset_src_two: assert property (@(posedge ref_clk)
		($past(rst) && !rst) |-> st.src1 == SRC_FRM_WAIT)
		else $error("output 2 source not frame wait after reset");
	// Non-user line follows its source, not the user value
	a_nonuser_follows: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src0 == SRC_EXPOSURE && !st.inv[0]) |=> out_line[0] == $past(evt.exposure_in_progress))
		else $error("non-user output 1 not following source");
	// Single-line write reaches the pin two cycles later
	a_single_level: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == REG_USER_LEVEL && st.src1 == SRC_USER && !st.inv[1]
		&& st.user_driven_line_pick && bus.wdata[0]) ##1 (st.src1 == SRC_USER && !st.inv[1])
		|=> out_line[1])
		else $error("user level not driven on picked line");
	a_multi_write: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == REG_USER_MULTI) |=> st.user_multi == $past(bus.wdata))
		else $error("multi value not stored");
	a_multi_low: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src0 == SRC_USER && !st.inv[0] && !st.user_multi[0]) |=> !out_line[0])
		else $error("multi bit 0 not driving low");
	a_invert_user: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src0 == SRC_USER && st.inv[0]) |=> out_line[0] == !$past(st.user_multi[0]))
		else $error("user value not ahead of inverter");
	a_snap_read: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.rd && bus.addr == REG_SNAPSHOT) |=> rdata[SNAP_OUT1_BIT +: 2] == $past(out_line))
		else $error("snapshot not matching driven levels");
	a_off_disable: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src1 == SRC_OFF) |=> !out_line_oe[1])
		else $error("off source still driving");

	// Further checks; bus terms in antecedents only pick the cycle to look at,
	// every consequent watches what this block drives
	// Pins and read data sit at zero in the cycle after reset is seen
	a_reset_quiet: assert property (@(posedge ref_clk)
		rst |=> (out_line == 2'h0 && out_line_oe == 2'h0 && rdata == 32'h0000_0000))
		else $error("outputs not quiet after reset");
	// Line 2 on its default source tracks the event, not the user bit
	a_nonuser_two: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src1 == SRC_FRM_WAIT && !st.inv[1])
		|=> out_line[1] == $past(evt.frame_trigger_waiting))
		else $error("non-user output 2 not following source");
	// A set multi bit drives a non-inverted user line high
	a_multi_high: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src0 == SRC_USER && !st.inv[0] && st.user_multi[0]) |=> out_line[0])
		else $error("multi bit 0 not driving high");
	// Bit 1 of the multi value belongs to output 2
	a_multi_two: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src1 == SRC_USER && !st.inv[1]) |=> out_line[1] == $past(st.user_multi[1]))
		else $error("multi bit 1 not on output 2");
	// Single-line write with output 1 picked lands in bit 0 only
	a_single_write: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == REG_USER_LEVEL && !st.user_driven_line_pick)
		|=> (st.user_multi[0] == $past(bus.wdata[0])
		&& st.user_multi[1] == $past(st.user_multi[1])))
		else $error("single user level not stored for output 1");
	// User line pick is taken from bit 0
	a_user_pick: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == REG_USER_PICK)
		|=> st.user_driven_line_pick == $past(bus.wdata[0]))
		else $error("user line pick not stored");
	// Inverter on output 1 turns the exposure level over
	a_invert_event: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src0 == SRC_EXPOSURE && st.inv[0])
		|=> out_line[0] == !$past(evt.exposure_in_progress))
		else $error("inverter not applied to output 1");
	// Inverter write for output 2 stores bit 0
	a_invert_store: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == REG_INVERT && st.io_line_pick == PICK_OUT2)
		|=> st.inv[1] == $past(bus.wdata[0]))
		else $error("inverter enable not stored for output 2");
	// Legal source codes are kept as written
	a_source_store: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == REG_SOURCE && st.io_line_pick == PICK_OUT2
		&& bus.wdata <= 32'h0000_0007) |=> st.src1 == $past(bus.wdata[3:0]))
		else $error("source code not stored for output 2");
	// Codes past the last source fall back to off
	a_source_legal: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == REG_SOURCE && st.io_line_pick == PICK_OUT1
		&& bus.wdata > 32'h0000_0007) |=> st.src0 == SRC_OFF)
		else $error("unknown source code not turned off");
	// Unassigned snapshot bits read as zero
	a_snap_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.rd && bus.addr == REG_SNAPSHOT) |=> (rdata[31:4] == 28'h000_0000 && !rdata[1]))
		else $error("snapshot spare bits not zero");
	// Input bit of the snapshot is the synchronised pin level
	a_snap_input: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.rd && bus.addr == REG_SNAPSHOT)
		|=> rdata[SNAP_IN1_BIT] == $past(st.in_sync[1]))
		else $error("snapshot input bit wrong");
	// Picked output 2 status is its driven level
	a_status_out: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.rd && bus.addr == REG_LINE_STATUS && st.io_line_pick == PICK_OUT2)
		|=> (rdata[0] == $past(out_line[1]) && rdata[31:1] == 31'h0000_0000))
		else $error("output 2 status wrong");
	// Status of output 1 is taken after the inverter
	a_status_inv: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.rd && bus.addr == REG_LINE_STATUS && st.io_line_pick == PICK_OUT1 && st.inv[0])
		|=> rdata[0] == $past(out_line[0]))
		else $error("output 1 status not after inverter");
	// Picked input status is the synchronised pin level
	a_status_in: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.rd && bus.addr == REG_LINE_STATUS && st.io_line_pick == PICK_IN1)
		|=> rdata[0] == $past(st.in_sync[1]))
		else $error("input status wrong");
	// Output 1 polarity follows its inverter
	a_polarity_out: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.rd && bus.addr == REG_POLARITY && st.io_line_pick == PICK_OUT1)
		|=> rdata == ($past(st.inv[0]) ? POL_NEGATIVE : POL_POSITIVE))
		else $error("output 1 polarity wrong");
	// The input line always reads positive logic
	a_polarity_in: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.rd && bus.addr == REG_POLARITY && st.io_line_pick == PICK_IN1)
		|=> rdata == POL_POSITIVE)
		else $error("input polarity not positive");
	// An off line is released and parked low
	a_off_level: assert property (@(posedge ref_clk) disable iff (rst)
		(st.src0 == SRC_OFF) |=> (!out_line_oe[0] && !out_line[0]))
		else $error("off output 1 still driving");

endmodule // cocl_line_ctrl

// [cocl_pkg.sv]
// Package for the camera output line control block: register map, fields, sources
package cocl_pkg;

	// Register word indices are byte addresses (all multiples of four)
	localparam logic [7:0] REG_LINE_PICK   = 8'h00; // Selector for per-line access
	localparam logic [7:0] REG_SOURCE      = 8'h04; // Source of picked output line
	localparam logic [7:0] REG_INVERT      = 8'h08; // Inverter of picked output line
	localparam logic [7:0] REG_USER_PICK   = 8'h0C; // User output line selector
	localparam logic [7:0] REG_USER_LEVEL  = 8'h10; // Single-line user level
	localparam logic [7:0] REG_USER_MULTI  = 8'h14; // Multi-line user value
	localparam logic [7:0] REG_LINE_STATUS = 8'h18; // Level of picked line
	localparam logic [7:0] REG_SNAPSHOT    = 8'h1C; // All line levels
	localparam logic [7:0] REG_POLARITY    = 8'h20; // Polarity kind of picked line

	// Line counts
	localparam int NUM_OUT = 2; // Output lines
	localparam int NUM_IN  = 1; // Input lines

	// Line pick codes: 0 = input line 1, 1 = output line 1, 2 = output line 2
	localparam logic [1:0] PICK_IN1  = 2'h0;
	localparam logic [1:0] PICK_OUT1 = 2'h1;
	localparam logic [1:0] PICK_OUT2 = 2'h2;

	// Snapshot bit positions
	localparam int SNAP_IN1_BIT  = 0; // Input line 1
	localparam int SNAP_OUT1_BIT = 2; // Output line 1 (output 2 follows)

	// Polarity codes
	localparam logic [31:0] POL_POSITIVE = 32'h0000_0000;
	localparam logic [31:0] POL_NEGATIVE = 32'h0000_0001;

	// Reset values
	localparam logic [31:0] USER_MULTI_RESET = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

	// Output source choices
	typedef enum logic [3:0] {
		SRC_EXPOSURE = 4'h0,
		SRC_ACQ_WAIT = 4'h1,
		SRC_FRM_WAIT = 4'h2,
		SRC_LIN_WAIT = 4'h3,
		SRC_ENCODER  = 4'h4,
		SRC_RATECONV = 4'h5,
		SRC_USER     = 4'h6,
		SRC_OFF      = 4'h7
	} cocl_src_e;

	// Register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cocl_bus_s;

	// Internal camera event signals
	typedef struct packed {
		logic exposure_in_progress;
		logic acquisition_trigger_waiting;
		logic frame_trigger_waiting;
		logic line_trigger_waiting;
		logic encoder_module_output;
		logic rate_converter_output;
	} cocl_evt_s;

endpackage // cocl_pkg

// [cocl_rx_model.sv]
// Far-side receiver and input source model for the camera line pins
`timescale 1ns/100ps
module cocl_rx_model (
	// Clock
	input  wire logic       ref_clk,
	// Camera output pins
	input  wire logic [1:0] out_line,
	input  wire logic [1:0] out_line_oe,
	// Level another camera puts on our input
	input  wire logic       src_level,
	// Receiver view and camera input pin
	output logic [1:0]      rx_level,
	output logic            in_line_pin
);
	// Undriven line toggles so a stale level never passes for a match
	initial rx_level = 2'h0;
	always @(posedge ref_clk)
	begin
		for (int i = 0; i < 2; i++)
			rx_level[i] <= out_line_oe[i] ? out_line[i] : ~rx_level[i];
		in_line_pin <= src_level;
	end
endmodule // cocl_rx_model

// [tb_top.sv]
// Self-checking bench for the camera output line control block
`timescale 1ns/100ps
module tb_top;
	import cocl_pkg::*;
	logic        ref_clk = 1'b0;   // 200 MHz clock
	logic        rst = 1'b1;       // Sync reset
	cocl_bus_s   bus = '0;         // Register requests
	cocl_evt_s   evt = '0;         // Camera events
	logic [31:0] rdata;            // Read data
	logic [1:0]  out_line;         // Output pins
	logic [1:0]  out_line_oe;      // Output enables
	logic [1:0]  rx_level;         // Receiver view
	logic        in_line_pin;      // Input pin
	logic        src_level = 1'b0; // Far camera level
	integer      seed = 32'hccff;  // Fixed seed
	integer      err_total = 0;
	integer      cmp_count = 0;
	integer      cyc = 0;
	logic [31:0] rv;               // Read result
	logic [31:0] mv;               // Multi value
	logic        inv;              // Inverter choice
	logic        u;                // User level
	// Clock
	always #2.5 ref_clk = ~ref_clk;
	// Hang guard, tests need about 500 cycles
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			end_sim();
		end
	end
	cocl_line_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .evt(evt),
		.in_line_pin(in_line_pin), .out_line(out_line), .out_line_oe(out_line_oe));
	cocl_rx_model u_rx (.ref_clk(ref_clk), .out_line(out_line), .out_line_oe(out_line_oe),
		.src_level(src_level), .rx_level(rx_level), .in_line_pin(in_line_pin));
	// Compare one value
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	// One-cycle write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask
	// One-cycle read, data in the next cycle only
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Let config and events reach the pins
	task automatic settle;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// New random events
	task automatic new_evt;
		@(posedge ref_clk);
		evt <= cocl_evt_s'(6'($random(seed)));
		src_level <= 1'($random(seed));
		settle();
	endtask
	// Expected level of a source ahead of the inverter
	function automatic logic src_lvl(input int c, input cocl_evt_s e, input logic usr);
		case (c)
			0: return e.exposure_in_progress;
			1: return e.acquisition_trigger_waiting;
			2: return e.frame_trigger_waiting;
			3: return e.line_trigger_waiting;
			4: return e.encoder_module_output;
			5: return e.rate_converter_output;
			6: return usr;
			default: return 1'b0;
		endcase
	endfunction
	// Verdict
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		// Default routing and snapshot
		repeat (8)
		begin
			new_evt();
			chk("oe", 32'h3, {30'h0, out_line_oe});
			chk("out1", 32'(evt.exposure_in_progress), 32'(out_line[0]));
			chk("out2", 32'(evt.frame_trigger_waiting), 32'(out_line[1]));
			chk("rx", {30'h0, evt.frame_trigger_waiting, evt.exposure_in_progress}, 32'(rx_level));
			rd(REG_SNAPSHOT, rv);
			chk("snap", {28'h0, evt.frame_trigger_waiting, evt.exposure_in_progress, 1'b0,
				src_level}, rv);
		end
		$display("test defaults done");
		// Multi value with line 2 on a camera source, then on the user value from the seventh pass
		wr(REG_LINE_PICK, 32'(PICK_OUT1));
		wr(REG_SOURCE, 32'h6);
		wr(REG_LINE_PICK, 32'(PICK_OUT2));
		wr(REG_SOURCE, 32'h0);
		for (int i = 0; i < 12; i++)
		begin
			mv = (i == 0) ? 32'hffff_fffc : $random(seed);
			if (i == 6)
				wr(REG_SOURCE, 32'h6);
			wr(REG_USER_MULTI, mv);
			new_evt();
			chk("m0", 32'(mv[0]), 32'(out_line[0]));
			chk("m1", 32'(i < 6 ? evt.exposure_in_progress : mv[1]), 32'(out_line[1]));
			rd(REG_USER_MULTI, rv);
			chk("mrb", mv, rv);
		end
		wr(REG_LINE_PICK, 32'(PICK_OUT1));
		wr(REG_INVERT, 32'h1);
		settle();
		chk("minv", {31'h0000_0000, ~mv[0]}, {31'h0000_0000, out_line[0]});
		$display("test multi done");
		// Every source on each line, with a random inverter and user level
		for (int l = 1; l <= 2; l++)
			for (int s = 0; s < 8; s++)
			begin
				inv = 1'($random(seed));
				u = 1'($random(seed));
				wr(REG_LINE_PICK, l);
				wr(REG_SOURCE, s);
				wr(REG_INVERT, 32'(inv));
				wr(REG_USER_PICK, l - 1);
				wr(REG_USER_LEVEL, 32'(u));
				new_evt();
				chk("oe", 32'(s != 7), 32'(out_line_oe[l-1]));
				if (s != 7)
					chk("lvl", 32'(src_lvl(s, evt, u) ^ inv), 32'(out_line[l-1]));
				rd(REG_LINE_STATUS, rv);
				chk("stat", 32'(s != 7 && (src_lvl(s, evt, u) ^ inv)), rv);
				rd(REG_POLARITY, rv);
				chk("pol", inv ? POL_NEGATIVE : POL_POSITIVE, rv);
			end
		rd(8'h3C, rv);
		chk("unmapped", UNMAPPED_READ, rv);
		$display("test sources done");
		// Source legalising, input line read-back and idle read data
		wr(REG_LINE_PICK, 32'(PICK_OUT1));
		wr(REG_SOURCE, 32'h0000_0010);
		rd(REG_SOURCE, rv);
		chk("legal", 32'(SRC_OFF), rv);
		wr(REG_LINE_PICK, 32'(PICK_IN1));
		new_evt();
		rd(REG_LINE_STATUS, rv);
		chk("in_stat", 32'(src_level), rv);
		rd(REG_POLARITY, rv);
		chk("in_pol", POL_POSITIVE, rv);
		@(posedge ref_clk);
		#1 chk("idle", 32'h0000_0000, rdata);
		$display("test picks done");
		end_sim();
	end
endmodule // tb_top
